//--- rtl/pei_top.sv
// PHY event interrupt, error counters and PCS configuration with Avalon-MM slave
`timescale 1ns/100ps
module pei_top #(
  parameter int CNT_W = pei_pkg::CNT_W
) (
  input wire logic mclk_i,                    // 100 MHz clock
  input wire logic rst_i,                     // Async reset, high
  input wire logic ce_i,                      // Clock enable, freezes all state
  input wire logic [7:0] avs_address_i,       // Byte address
  input wire logic avs_read_i,                // Read request
  input wire logic avs_write_i,               // Write request
  input wire logic [31:0] avs_writedata_i,    // Write data
  input wire logic [3:0] avs_byteenable_i,    // Byte lanes
  output logic [31:0] avs_readdata_o,         // Read data
  output logic avs_waitrequest_o,             // Stall
  input wire logic link_status_i,             // Link up level
  input wire logic jabber_i,                  // Jabber level
  input wire logic remote_fault_i,            // Remote fault level
  input wire logic autoneg_done_i,            // Autoneg complete level
  input wire logic false_carrier_i,           // One pulse per false carrier
  input wire logic carrier_i,                 // Valid carrier level
  input wire logic symbol_error_i,            // Invalid data symbol pulse
  input wire logic collision_i,               // Collision level
  input wire logic mac_fast_link_override_i,  // MAC forced fast link, async
  output logic irq_pending_o,                 // PHY interrupt to top status
  output logic block_code_skip_o,             // Bypass block coder
  output logic rx_clk_free_run_o,             // Free-running receive clock
  output logic tx_true_quiet_o,               // True quiet transmit
  output logic signal_detect_override_o,      // Force signal detect
  output logic signal_detect_algorithm_sel_o, // Enhanced detect algorithm
  output logic fast_link_good_o,              // Forced good fast link
  output logic line_code_skip_o               // Bypass line coding
);
  typedef struct packed {
    logic [1:0] ctl;
    logic [pei_pkg::NUM_EV-1:0] mask;
    logic pend;
    logic [15:0] pcs;
    logic ack;
    logic [31:0] rdata;
    logic link_d;
    logic jab_d;
    logic rf_d;
    logic anc_d;
    logic carr_d;
    logic err_seen;
    logic coll_seen;
    logic fast_link;
  } pei_state_t;

  pei_state_t st_reg;
  pei_state_t st_next;

  logic req;
  logic rd_snap;
  logic rd_done;
  logic wr_go;
  logic sel_ctl;
  logic sel_stat;
  logic sel_fc;
  logic sel_rx;
  logic sel_pcs;
  logic [15:0] wmask;
  logic [15:0] wval;
  logic [CNT_W-1:0] fc_cnt;
  logic [CNT_W-1:0] rx_cnt;
  logic fc_half;
  logic rx_half;
  logic rx_inc;
  logic mac_link;
  logic [pei_pkg::NUM_EV-1:0] ev;
  logic ev_hit;
  logic [15:0] rd_val;

  // Request stalls exactly one cycle; reads are committed at the first edge
  assign req = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~st_reg.ack;
  assign rd_snap = ce_i & avs_read_i & ~st_reg.ack;
  assign rd_done = ce_i & avs_read_i & st_reg.ack;
  assign wr_go = ce_i & avs_write_i & st_reg.ack;

  assign sel_ctl = avs_address_i == pei_pkg::OFS_IRQ_CTL;
  assign sel_stat = avs_address_i == pei_pkg::OFS_IRQ_STAT;
  assign sel_fc = avs_address_i == pei_pkg::OFS_FC_CNT;
  assign sel_rx = avs_address_i == pei_pkg::OFS_RX_CNT;
  assign sel_pcs = avs_address_i == pei_pkg::OFS_PCS;

  // Upper half-word lanes hold nothing, only lanes 0 and 1 matter
  assign wmask = {{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  assign wval = avs_writedata_i[15:0];

  // Bad symbol counted at carrier end, so a late collision still vetoes it
  assign rx_inc = st_reg.carr_d & ~carrier_i & st_reg.err_seen
                  & ~st_reg.coll_seen & ~collision_i;

  pei_sync u_mac_sync (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .d_i(mac_fast_link_override_i),
    .q_o(mac_link)
  );

  pei_sat_counter #(.W(CNT_W)) u_fc_cnt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .inc_i(false_carrier_i),
    .clr_i(rd_snap & sel_fc),
    .wr_i(wr_go & sel_fc & avs_byteenable_i[0]),
    .wdata_i(wval[CNT_W-1:0]),
    .cnt_o(fc_cnt),
    .half_o(fc_half)
  );

  pei_sat_counter #(.W(CNT_W)) u_rx_cnt (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .inc_i(rx_inc),
    .clr_i(rd_snap & sel_rx),
    .wr_i(wr_go & sel_rx & avs_byteenable_i[0]),
    .wdata_i(wval[CNT_W-1:0]),
    .cnt_o(rx_cnt),
    .half_o(rx_half)
  );

  // Event sources, one bit per mask position
  always_comb begin
    ev = '0;
    ev[pei_pkg::EV_LINK] = link_status_i ^ st_reg.link_d;
    ev[pei_pkg::EV_JAB] = jabber_i & ~st_reg.jab_d;
    ev[pei_pkg::EV_RF] = remote_fault_i & ~st_reg.rf_d;
    ev[pei_pkg::EV_ANC] = autoneg_done_i & ~st_reg.anc_d;
    ev[pei_pkg::EV_FCH] = fc_half;
    ev[pei_pkg::EV_RXH] = rx_half;
  end

  assign ev_hit = st_reg.ctl[pei_pkg::CTL_EVEN_BIT]
                  & |(ev & ~st_reg.mask);

  // Read mux; unmapped offsets read zero
  always_comb begin
    rd_val = 16'h0000;
    if (sel_ctl) begin
      rd_val[1:0] = st_reg.ctl;
    end else if (sel_stat) begin
      rd_val[pei_pkg::STAT_PEND_BIT] = st_reg.pend;
      rd_val[pei_pkg::STAT_MASK_HI:pei_pkg::STAT_MASK_LO] = st_reg.mask;
    end else if (sel_fc) begin
      rd_val[CNT_W-1:0] = fc_cnt;
    end else if (sel_rx) begin
      rd_val[CNT_W-1:0] = rx_cnt;
    end else if (sel_pcs) begin
      rd_val = st_reg.pcs;
    end
  end

  always_comb begin
    st_next = st_reg;
    st_next.ack = req & ~st_reg.ack;
    st_next.link_d = link_status_i;
    st_next.jab_d = jabber_i;
    st_next.rf_d = remote_fault_i;
    st_next.anc_d = autoneg_done_i;
    st_next.carr_d = carrier_i;
    st_next.fast_link = st_reg.pcs[pei_pkg::PCS_FLNK_BIT] | mac_link;

    if (carrier_i && !st_reg.carr_d) begin
      st_next.err_seen = symbol_error_i;
      st_next.coll_seen = collision_i;
    end else if (carrier_i) begin
      st_next.err_seen = st_reg.err_seen | symbol_error_i;
      st_next.coll_seen = st_reg.coll_seen | collision_i;
    end else begin
      st_next.err_seen = 1'b0;
      st_next.coll_seen = 1'b0;
    end

    if (rd_snap) begin
      st_next.rdata = {16'h0000, rd_val};
    end

    if (wr_go && sel_ctl) begin
      st_next.ctl = (st_reg.ctl & ~wmask[1:0]) | (wval[1:0] & wmask[1:0]);
    end
    if (wr_go && sel_stat) begin
      st_next.mask = (st_reg.mask & ~wmask[pei_pkg::STAT_MASK_HI:pei_pkg::STAT_MASK_LO])
                     | (wval[pei_pkg::STAT_MASK_HI:pei_pkg::STAT_MASK_LO]
                     & wmask[pei_pkg::STAT_MASK_HI:pei_pkg::STAT_MASK_LO]);
    end
    if (wr_go && sel_pcs) begin
      // Only the documented configuration bits can be written
      st_next.pcs = (st_reg.pcs & ~(wmask & pei_pkg::PCS_WMASK))
                    | (wval & wmask & pei_pkg::PCS_WMASK);
    end

    // Read of the status clears pending; a new set in that cycle wins
    if (rd_snap && sel_stat) begin
      st_next.pend = 1'b0;
    end
    if (ev_hit) begin
      st_next.pend = 1'b1;
    end
    if (rd_done && st_reg.ctl[pei_pkg::CTL_TEST_BIT]) begin
      st_next.pend = 1'b1;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
      st_reg.ctl <= pei_pkg::CTL_RST;
      st_reg.mask <= pei_pkg::MASK_RST;
      st_reg.pcs <= pei_pkg::PCS_RST;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata_o = st_reg.rdata;
  assign irq_pending_o = st_reg.pend;
  assign block_code_skip_o = st_reg.pcs[pei_pkg::PCS_BLK_BIT];
  assign rx_clk_free_run_o = st_reg.pcs[pei_pkg::PCS_FREE_BIT];
  assign tx_true_quiet_o = st_reg.pcs[pei_pkg::PCS_TQ_BIT];
  assign signal_detect_override_o = st_reg.pcs[pei_pkg::PCS_SDF_BIT];
  assign signal_detect_algorithm_sel_o = st_reg.pcs[pei_pkg::PCS_SDA_BIT];
  assign fast_link_good_o = st_reg.fast_link;
  assign line_code_skip_o = st_reg.pcs[pei_pkg::PCS_LINE_BIT];
endmodule : pei_top

//--- rtl/pei_pkg.sv
// Register map, field layout and reset values of the PHY event interrupt block
package pei_pkg;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int REG_W = 16;
  localparam int CNT_W = 8;

  localparam logic [7:0] OFS_IRQ_CTL = 8'hC4;
  localparam logic [7:0] OFS_IRQ_STAT = 8'hC8;
  localparam logic [7:0] OFS_FC_CNT = 8'hD0;
  localparam logic [7:0] OFS_RX_CNT = 8'hD4;
  localparam logic [7:0] OFS_PCS = 8'hD8;

  localparam int CTL_TEST_BIT = 0;
  localparam int CTL_EVEN_BIT = 1;
  localparam logic [1:0] CTL_RST = 2'h0;

  localparam int STAT_PEND_BIT = 15;
  localparam int STAT_MASK_LO = 9;
  localparam int STAT_MASK_HI = 14;
  localparam int NUM_EV = 6;
  localparam logic [5:0] MASK_RST = 6'h00;
  // Event index inside the mask field, highest bit first
  localparam int EV_LINK = 5;
  localparam int EV_JAB = 4;
  localparam int EV_RF = 3;
  localparam int EV_ANC = 2;
  localparam int EV_FCH = 1;
  localparam int EV_RXH = 0;

  localparam logic [7:0] CNT_RST = 8'h00;

  localparam int PCS_BLK_BIT = 12;
  localparam int PCS_FREE_BIT = 11;
  localparam int PCS_TQ_BIT = 10;
  localparam int PCS_SDF_BIT = 9;
  localparam int PCS_SDA_BIT = 8;
  localparam int PCS_FLNK_BIT = 5;
  localparam int PCS_LINE_BIT = 2;
  localparam logic [15:0] PCS_WMASK = 16'h1F24;
  localparam logic [15:0] PCS_RST = 16'h0100;
endpackage : pei_pkg

//--- rtl/pei_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/100ps
module pei_sync (
  input wire logic mclk_i, // Clock
  input wire logic rst_i,  // Async reset, high
  input wire logic ce_i,   // Clock enable
  input wire logic d_i,    // Asynchronous level
  output logic q_o         // Filtered level
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } pei_sync_t;

  pei_sync_t st_reg;
  pei_sync_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.s1 = d_i;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    // Stage one feeds only stage two; later stages vote
    if (st_reg.s2 == st_reg.s3) begin
      st_next.q = st_reg.s3;
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign q_o = st_reg.q;
endmodule : pei_sync

//--- rtl/pei_sat_counter.sv
// Saturating clear-on-read event counter with half-full detect
`timescale 1ns/100ps
module pei_sat_counter #(
  parameter int W = 8
) (
  input wire logic mclk_i,          // Clock
  input wire logic rst_i,           // Async reset, high
  input wire logic ce_i,            // Clock enable
  input wire logic inc_i,           // Count one event
  input wire logic clr_i,           // Clear, read side effect
  input wire logic wr_i,            // Software load
  input wire logic [W-1:0] wdata_i, // Load value
  output logic [W-1:0] cnt_o,       // Current count
  output logic half_o               // Pulse on entering half-full
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic msb_d;
  } pei_cnt_t;

  pei_cnt_t st_reg;
  pei_cnt_t st_next;

  always_comb begin
    st_next = st_reg;
    st_next.msb_d = st_reg.cnt[W-1];
    if (wr_i) begin
      st_next.cnt = wdata_i;
    end else if (clr_i) begin
      // Increment in the clearing cycle survives
      st_next.cnt = inc_i ? W'(1) : '0;
    end else if (inc_i && st_reg.cnt != {W{1'b1}}) begin
      st_next.cnt = st_reg.cnt + W'(1);
    end
  end

  always_ff @(posedge mclk_i or posedge rst_i) begin
    if (rst_i) begin
      st_reg <= '0;
    end else if (ce_i) begin
      st_reg <= st_next;
    end
  end

  assign cnt_o = st_reg.cnt;
  assign half_o = ce_i & st_reg.cnt[W-1] & ~st_reg.msb_d;
endmodule : pei_sat_counter

//--- tb/pei_top_properties.sv
// Port-level checks for the PHY event interrupt block
`timescale 1ns/100ps
module pei_props #(
  parameter int CNT_W = 8
) (
  input wire logic mclk_i, // Clock
  input wire logic rst_i, // Async reset
  input wire logic [7:0] avs_address_i, // Address
  input wire logic avs_read_i, // Read
  input wire logic avs_write_i, // Write
  input wire logic [31:0] avs_writedata_i, // Write data
  input wire logic [3:0] avs_byteenable_i, // Lanes
  input wire logic [31:0] avs_readdata_o, // Read data
  input wire logic avs_waitrequest_o, // Stall
  input wire logic mac_fast_link_override_i, // MAC override
  input wire logic irq_pending_o, // Interrupt
  input wire logic block_code_skip_o, // PCS 12
  input wire logic rx_clk_free_run_o, // PCS 11
  input wire logic tx_true_quiet_o, // PCS 10
  input wire logic signal_detect_override_o, // PCS 9
  input wire logic signal_detect_algorithm_sel_o, // PCS 8
  input wire logic fast_link_good_o, // PCS 5 or MAC
  input wire logic line_code_skip_o // PCS 2
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  logic hi;
  logic lo;
  logic snap;
  // A write lands on the edge where waitrequest is low
  assign hi = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'hD8 && avs_byteenable_i[1];
  assign lo = avs_write_i && !avs_waitrequest_o && avs_address_i == 8'hD8 && avs_byteenable_i[0];
  assign snap = avs_read_i && avs_waitrequest_o;
  cnt_upper_a: assert property (
    snap && avs_address_i[7:3] == 5'h1A |=> avs_readdata_o[31:8] == 24'h000000)
    else $error("counter upper bits set");
  pend_read_a: assert property (
    snap && avs_address_i == 8'hC8 |=> avs_readdata_o[15] == $past(irq_pending_o))
    else $error("pending bit mismatch");
  sd_reset_a: assert property (
    $fell(rst_i) |-> signal_detect_algorithm_sel_o && !block_code_skip_o)
    else $error("PCS reset value wrong");
  code_skip_a: assert property (
    hi |=> block_code_skip_o == $past(avs_writedata_i[12])) else $error("bit 12 output");
  free_clk_a: assert property (
    hi |=> rx_clk_free_run_o == $past(avs_writedata_i[11])) else $error("bit 11 output");
  true_quiet_a: assert property (
    hi |=> tx_true_quiet_o == $past(avs_writedata_i[10])) else $error("bit 10 output");
  sd_force_a: assert property (
    hi |=> signal_detect_override_o == $past(avs_writedata_i[9])) else $error("bit 9 output");
  line_skip_a: assert property (
    lo |=> line_code_skip_o == $past(avs_writedata_i[2])) else $error("bit 2 output");
  fast_mac_a: assert property (
    $rose(mac_fast_link_override_i) |-> ##[1:8] fast_link_good_o) else $error("fast link late");
  cover property (snap && avs_address_i == 8'hC8 && irq_pending_o);
  cover property ($rose(fast_link_good_o));
  cover property (hi);
endmodule : pei_props
bind pei_top pei_props #(.CNT_W(CNT_W)) pei_props_i (.*);

//--- tb/pei_top_tb_top.sv
// Self-checking bench for the PHY event interrupt block
`timescale 1ns/100ps
module pei_top_tb_top;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] adr = 8'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rdat;
  logic wt;
  logic [3:0] lv = 4'h0;
  logic fc = 1'b0;
  logic car = 1'b0;
  logic se = 1'b0;
  logic col = 1'b0;
  logic mac = 1'b0;
  logic ce = 1'b1;
  logic irq;
  logic [6:0] pcs;
  logic [15:0] q;
  int errors = 0;
  int cmp_count = 0;
  always #5 mclk_i = ~mclk_i;
  pei_top pei_top_i (
    .mclk_i(mclk_i), .rst_i(rst_i), .ce_i(ce), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wt), .link_status_i(lv[3]),
    .jabber_i(lv[2]), .remote_fault_i(lv[1]), .autoneg_done_i(lv[0]),
    .false_carrier_i(fc), .carrier_i(car), .symbol_error_i(se), .collision_i(col),
    .mac_fast_link_override_i(mac), .irq_pending_o(irq), .block_code_skip_o(pcs[6]),
    .rx_clk_free_run_o(pcs[5]), .tx_true_quiet_o(pcs[4]),
    .signal_detect_override_o(pcs[3]), .signal_detect_algorithm_sel_o(pcs[2]),
    .fast_link_good_o(pcs[1]), .line_code_skip_o(pcs[0]));
  task automatic conclude;
    $display("errors %0d comparisons %0d", errors, cmp_count);
    if (errors == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : conclude
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : tick
  // Holds the request until waitrequest is seen low, then releases for a cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    adr <= a;
    wd <= {16'h0000, d};
    wr <= w;
    rd <= ~w;
    @(negedge mclk_i);
    while (wt !== 1'b0 && n < 50) begin
      n++;
      @(negedge mclk_i);
    end
    if (n >= 50) begin
      chk(16'h0000, 16'h0001);
      conclude();
    end
    // Waitrequest is low in this cycle, so the coming rising edge accepts
    @(posedge mclk_i);
    q = rdat[15:0];
    wr <= 1'b0;
    rd <= 1'b0;
    @(posedge mclk_i);
  endtask : bus
  task automatic rdc(input logic [7:0] a, input logic [15:0] e);
    bus(1'b0, a, 16'h0000);
    chk(q, e);
  endtask : rdc
  task automatic rx(input int n, input logic c);
    car <= 1'b1;
    col <= c;
    tick(2);
    repeat (n) begin
      se <= 1'b1;
      tick(1);
      se <= 1'b0;
      tick(1);
    end
    car <= 1'b0;
    tick(1);
    col <= 1'b0;
    tick(3);
  endtask : rx
  task automatic t_regs;
    rdc(8'hC4, 16'h0000);
    rdc(8'hD0, 16'h0000);
    rdc(8'hD4, 16'h0000);
    rdc(8'hD8, 16'h0100);
    bus(1'b1, 8'hC4, 16'hFFFC);
    rdc(8'hC4, 16'h0000);
    bus(1'b1, 8'hD0, 16'hFFFF);
    rdc(8'hD0, 16'h00FF);
    rdc(8'hD0, 16'h0000);
    bus(1'b1, 8'hD8, 16'hFFFF);
    rdc(8'hD8, 16'h1F24);
    chk({9'h000, pcs}, 16'h007F);
    bus(1'b1, 8'hD8, 16'h0000);
    // Forced link output settles one edge after the PCS bit
    tick(1);
    chk({9'h000, pcs}, 16'h0000);
    bus(1'b1, 8'hD8, 16'h0100);
    // An unmapped write must leave every register alone
    bus(1'b1, 8'hC0, 16'hFFFF);
    rdc(8'hC0, 16'h0000);
    rdc(8'hD8, 16'h0100);
  endtask : t_regs
  task automatic t_event;
    int i;
    bus(1'b1, 8'hC4, 16'h0002);
    bus(1'b0, 8'hC8, 16'h0000);
    for (i = 0; i < 4; i++) begin
      lv[i] <= 1'b1;
      tick(3);
      chk({15'h0, irq}, 16'h0001);
      rdc(8'hC8, 16'h8000);
      chk({15'h0, irq}, 16'h0000);
      lv[i] <= 1'b0;
      tick(3);
      bus(1'b0, 8'hC8, 16'h0000);
    end
    bus(1'b1, 8'hC8, 16'h5E00);
    lv[3] <= 1'b1;
    tick(3);
    chk({15'h0, irq}, 16'h0000);
    lv[2] <= 1'b1;
    tick(3);
    rdc(8'hC8, 16'hDE00);
    bus(1'b1, 8'hC4, 16'h0000);
    bus(1'b1, 8'hC8, 16'h0000);
    lv <= 4'h2;
    tick(3);
    chk({15'h0, irq}, 16'h0000);
    lv <= 4'h0;
  endtask : t_event
  task automatic t_test;
    bus(1'b0, 8'hD8, 16'h0000);
    chk({15'h0, irq}, 16'h0000);
    bus(1'b1, 8'hC4, 16'h0001);
    bus(1'b0, 8'hD8, 16'h0000);
    chk({15'h0, irq}, 16'h0001);
    bus(1'b1, 8'hC4, 16'h0000);
    rdc(8'hC8, 16'h8000);
  endtask : t_test
  task automatic t_count;
    bus(1'b1, 8'hC4, 16'h0002);
    bus(1'b1, 8'hD0, 16'h007E);
    fc <= 1'b1;
    tick(3);
    fc <= 1'b0;
    tick(3);
    chk({15'h0, irq}, 16'h0001);
    rdc(8'hD0, 16'h0081);
    bus(1'b1, 8'hD0, 16'h00FE);
    fc <= 1'b1;
    tick(3);
    fc <= 1'b0;
    tick(2);
    rdc(8'hD0, 16'h00FF);
    rdc(8'hD0, 16'h0000);
    bus(1'b1, 8'hD4, 16'h007F);
    bus(1'b0, 8'hC8, 16'h0000);
    rx(1, 1'b0);
    chk({15'h0, irq}, 16'h0001);
    rx(2, 1'b0);
    rx(1, 1'b1);
    rx(0, 1'b0);
    rdc(8'hD4, 16'h0081);
    rdc(8'hD4, 16'h0000);
    bus(1'b1, 8'hD4, 16'h00FF);
    rx(1, 1'b0);
    rdc(8'hD4, 16'h00FF);
    bus(1'b1, 8'hC4, 16'h0000);
  endtask : t_count
  // Clock enable low must drop false carrier pulses
  task automatic t_freeze;
    ce <= 1'b0;
    fc <= 1'b1;
    tick(4);
    fc <= 1'b0;
    ce <= 1'b1;
    tick(1);
    rdc(8'hD0, 16'h0000);
  endtask : t_freeze
  task automatic t_link;
    mac <= 1'b1;
    tick(10);
    chk({9'h000, pcs}, 16'h0006);
    mac <= 1'b0;
    tick(10);
    chk({9'h000, pcs}, 16'h0004);
    bus(1'b1, 8'hD8, 16'h0120);
    tick(1);
    chk({9'h000, pcs}, 16'h0006);
  endtask : t_link
  initial begin
    tick(16);
    rst_i <= 1'b0;
    tick(1);
    t_regs();
    t_event();
    t_test();
    t_count();
    t_freeze();
    t_link();
    conclude();
  end
endmodule : pei_top_tb_top
